// ---- src/mux_adc_serial_control.sv ----
// Serial control of the channel selector and 12-bit sampling converter
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
module mux_adc_serial_control
    import adc_serial_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // APB slave
    input wire logic [11:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Serial link
    input wire logic i_sclk,
    input wire logic i_channel_address_select_n,
    input wire logic i_conversion_select_n,
    input wire logic i_sdata,
    output logic o_sdata,
    output logic o_sdata_oe,
    // Analog controls
    output logic [7:0] o_chan_on,
    output logic o_converter_power,
    output logic o_reference_connect,
    output logic o_hold
);
    localparam int SW_DLY = SWITCH_ON_CYCLES;

    // ----------------------------------------
    // Decode functions
    // ----------------------------------------
    function automatic logic [2:0] chan_num(input logic [3:0] word, input logic narrow);
        chan_num = narrow ? {1'b0, word[1:0]} : word[2:0];
    endfunction

    function automatic logic [7:0] chan_decode(input logic [3:0] word, input logic narrow);
        chan_decode = word[WORD_EN_BIT] ? (8'h01 << chan_num(word, narrow)) : 8'h00;
    endfunction

    function automatic logic serial_bit(input logic [4:0] n, input logic [RESULT_W-1:0] code);
        if (n > HOLD_FALL && n <= CONV_END_FALL) begin
            serial_bit = code[4'(CONV_END_FALL - n)];
        end else if (n > CONV_END_FALL && n <= LSB_END_FALL) begin
            serial_bit = code[4'(n - CONV_END_FALL)];
        end else begin
            serial_bit = 1'b0;
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers and edges
    // ----------------------------------------
    logic [3:0] pins_s;
    logic sclk_d_r;
    logic csm_d_r;
    logic csa_d_r;

    pin_sync #(.W(4)) u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async({i_sclk, i_channel_address_select_n, i_conversion_select_n, i_sdata}),
        .o_sync(pins_s)
    );

    wire sclk_s = pins_s[3];
    wire csm_s = pins_s[2];
    wire csa_s = pins_s[1];
    wire din_s = pins_s[0];
    wire sclk_rise = sclk_s && !sclk_d_r;
    wire sclk_fall = !sclk_s && sclk_d_r;
    wire csm_fall = !csm_s && csm_d_r;
    wire csa_fall = !csa_s && csa_d_r;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sclk_d_r <= 1'b0;
            csm_d_r <= 1'b0;
            csa_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            csm_d_r <= csm_s;
            csa_d_r <= csa_s;
        end
    end

    // ----------------------------------------
    // Registers and FIFO
    // ----------------------------------------
    logic [31:0] ctrl_r;
    logic underrun_r;
    logic [31:0] prdata_r;
    logic [RESULT_W-1:0] result_r;
    conv_state_t state_r;
    conv_state_t state_nxt;
    logic [4:0] fall_cnt_r;
    logic [3:0] addr_shift_r;
    logic [3:0] chan_word_r;
    logic [7:0] switch_cnt_r;
    logic [7:0] chan_on_r;
    logic sdata_r;
    logic sdata_oe_r;
    logic fifo_wready;
    logic fifo_rvalid;
    logic [RESULT_W-1:0] fifo_rdata;
    logic [LEVEL_W-1:0] fifo_level;

    wire narrow = ctrl_r[CTRL_NARROW_BIT];
    wire setup = i_psel && !i_penable;
    wire access = i_psel && i_penable;
    wire sel_ctrl = i_paddr == OFS_CTRL;
    wire sel_status = i_paddr == OFS_STATUS;
    wire sel_sample = i_paddr == OFS_SAMPLE;
    wire sel_result = i_paddr == OFS_RESULT;
    wire mapped = sel_ctrl || sel_status || sel_sample || sel_result;
    wire sample_push = access && i_pwrite && sel_sample;
    wire wr_done = access && i_pwrite && o_pready;
    wire hold_edge = state_r == ST_SAMPLE && sclk_fall && fall_cnt_r == HOLD_FALL - 5'h01;
    wire underrun_set = hold_edge && !fifo_rvalid;
    wire underrun_clr = wr_done && sel_status && i_pwdata[ST_UNDERRUN_BIT];

    // A full FIFO stalls the sample write until a conversion drains a word
    assign o_pready = !(sample_push && !fifo_wready);
    assign o_pslverr = access && !mapped;
    assign o_prdata = prdata_r;

    wire [31:0] status_word = {18'h0, 2'(fifo_level >> 4), fifo_level[3:0], 1'b0, state_r,
        chan_num(chan_word_r, narrow), chan_word_r[WORD_EN_BIT], underrun_r};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_r :
        sel_status ? status_word :
        sel_result ? {20'h0_0000, result_r} : 32'h0000_0000;

    sample_fifo #(.W(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_wvalid(sample_push),
        .i_wdata(i_pwdata[RESULT_W-1:0]),
        .o_wready(fifo_wready),
        .i_rready(hold_edge),
        .o_rvalid(fifo_rvalid),
        .o_rdata(fifo_rdata),
        .o_level(fifo_level)
    );

    // Read data captured in setup so it is stable in the access phase
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_r <= CTRL_RST;
            underrun_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            if (wr_done && sel_ctrl) begin
                ctrl_r <= {31'h0, i_pwdata[CTRL_NARROW_BIT]};
            end
            underrun_r <= underrun_set || (underrun_r && !underrun_clr);
            if (setup && !i_pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // Address word and channel switches
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            addr_shift_r <= 4'h0;
            chan_word_r <= 4'h0;
            switch_cnt_r <= 8'h00;
            chan_on_r <= 8'h00;
        end else begin
            if (csm_s && sclk_rise) begin
                addr_shift_r <= {addr_shift_r[2:0], din_s};
            end
            if (csm_fall) begin
                chan_word_r <= addr_shift_r;
                switch_cnt_r <= 8'(SWITCH_ON_CYCLES);
                chan_on_r <= 8'h00;
            end else if (switch_cnt_r != 8'h00) begin
                switch_cnt_r <= switch_cnt_r - 8'h01;
                if (switch_cnt_r == 8'h01) begin
                    chan_on_r <= chan_decode(chan_word_r, narrow);
                end
            end
        end
    end

    assign o_chan_on = chan_on_r;

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (csa_fall) begin
                    state_nxt = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (hold_edge) begin
                    state_nxt = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (sclk_fall && fall_cnt_r == CONV_END_FALL - 5'h01) begin
                    state_nxt = ST_TRAIL;
                end
            end
            ST_TRAIL: begin
                state_nxt = ST_TRAIL;
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
        if (csa_s) begin
            state_nxt = ST_OFF;
        end
    end

    wire [4:0] fall_next = fall_cnt_r + 5'h01;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= ST_OFF;
            fall_cnt_r <= 5'h00;
            result_r <= '0;
            sdata_r <= 1'b0;
            sdata_oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (csa_s || csa_fall) begin
                fall_cnt_r <= 5'h00;
            end else if (sclk_fall && fall_cnt_r != FALL_MAX) begin
                fall_cnt_r <= fall_next;
            end
            if (hold_edge) begin
                result_r <= fifo_rvalid ? fifo_rdata : '0;
            end
            if (csa_s) begin
                sdata_oe_r <= 1'b0;
                sdata_r <= 1'b0;
            end else if (sclk_fall && state_r != ST_OFF) begin
                if (fall_next == HOLD_FALL) begin
                    sdata_oe_r <= 1'b1;
                end
                sdata_r <= serial_bit(fall_next, result_r);
            end
        end
    end

    assign o_sdata = sdata_r;
    assign o_sdata_oe = sdata_oe_r;
    assign o_converter_power = state_r == ST_SAMPLE || state_r == ST_CONVERT;
    assign o_reference_connect = o_converter_power;
    assign o_hold = state_r == ST_CONVERT;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_hold;
        state_r == ST_SAMPLE && hold_edge;
    endsequence

    sequence s_mux_open;
        csm_fall && addr_shift_r[WORD_EN_BIT];
    endsequence

    AST_OE_RELEASED: assert property (csa_s |=> !o_sdata_oe)
        else $error("data line driven while select high");
    AST_POWER_DOWN: assert property (csa_s |=> !o_converter_power && !o_reference_connect)
        else $error("converter powered while select high");
    AST_HOLD_SECOND_FALL: assert property (s_hold |=> o_hold && fall_cnt_r == HOLD_FALL)
        else $error("hold not entered on second falling edge");
    AST_CONV_LENGTH: assert property ($fell(o_hold) && !csa_s |-> fall_cnt_r == CONV_END_FALL)
        else $error("conversion did not last twelve clocks");
    AST_POWER_ENDS: assert property ($fell(o_converter_power) |-> csa_s || fall_cnt_r == CONV_END_FALL)
        else $error("converter power dropped at wrong time");
    AST_ALL_OFF: assert property (!chan_word_r[WORD_EN_BIT] |-> o_chan_on == 8'h00)
        else $error("channel on while enable bit clear");
    AST_ONE_CHANNEL: assert property ($onehot0(o_chan_on))
        else $error("more than one channel on");
    AST_BREAK_BEFORE_MAKE: assert property (s_mux_open |=> (o_chan_on == 8'h00)[*8])
        else $error("channel switched on before delay");
    AST_SWITCH_ON: assert property (s_mux_open ##1 !csm_fall [*3] |-> ##(SW_DLY - 2) o_chan_on != 8'h00 || csm_fall)
        else $error("channel not switched on after delay");
    AST_NULL_BIT: assert property (s_hold |=> o_sdata_oe && !o_sdata)
        else $error("null bit missing after hold");
    AST_MSB_FIRST: assert property (!csa_s && sclk_fall && fall_cnt_r == HOLD_FALL |=> o_sdata == result_r[11])
        else $error("result MSB not first");
    AST_SHIFT_HELD: assert property (!csm_s |=> $stable(addr_shift_r))
        else $error("address shifted while select low");
    AST_STRAIGHT_CODE: assert property (s_hold ##0 fifo_rvalid |=> result_r == $past(fifo_rdata))
        else $error("result code altered");
endmodule

// ---- inc/adc_serial_pkg.sv ----
// Shared constants and types for the serial converter control block
package adc_serial_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_SAMPLE = 12'h008;
    localparam logic [11:0] OFS_RESULT = 12'h00C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_NARROW_BIT = 0;
    localparam int ST_UNDERRUN_BIT = 0;
    localparam int ST_CHAN_EN_BIT = 1;
    localparam int ST_CHAN_LSB = 2;
    localparam int ST_PHASE_LSB = 5;
    localparam int ST_LEVEL_LSB = 8;
    localparam int WORD_EN_BIT = 3;

    // ----------------------------------------
    // Widths and depths
    // ----------------------------------------
    localparam int RESULT_W = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int LEVEL_W = 6;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SWITCH_ON_DELAY_NS = 500;
    localparam int SWITCH_ON_CYCLES = (SWITCH_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYCLES = 12;
    localparam logic [4:0] HOLD_FALL = 5'h02;
    localparam logic [4:0] CONV_END_FALL = 5'h0E;
    localparam logic [4:0] LSB_END_FALL = 5'h19;
    localparam logic [4:0] FALL_MAX = 5'h1F;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_TRAIL = 2'b11
    } conv_state_t;

endpackage

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Pins
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= i_async[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_r;
endmodule

// ---- src/sample_fifo.sv ----
// Sample word FIFO with registered read data
`timescale 1ns/1ps
module sample_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Fill side
    input wire logic i_wvalid,
    input wire logic [W-1:0] i_wdata,
    output logic o_wready,
    // Drain side
    input wire logic i_rready,
    output logic o_rvalid,
    output logic [W-1:0] o_rdata,
    output logic [$clog2(DEPTH+1)-1:0] o_level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic [W-1:0] rdata_r;
    wire push = i_wvalid && o_wready;
    wire pop = i_rready && o_rvalid;
    wire [PW-1:0] rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;

    assign o_wready = count_r != FULL;
    assign o_rvalid = count_r != '0;
    assign o_rdata = rdata_r;
    assign o_level = count_r;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_wdata;
        end
    end

    // Bypass keeps the head word fresh when writing into the slot being read
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            rdata_r <= '0;
        end else begin
            wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= CW'(count_r + CW'(push) - CW'(pop));
            rdata_r <= (push && wr_ptr_r == rd_ptr_nxt) ? i_wdata : mem_r[rd_ptr_nxt];
        end
    end
endmodule

// ---- testbench/host_link_model.sv ----
// Host-side model of the serial link: shift clock, selects, shared data wire
`timescale 1ns/1ps
module host_link_model (
    // Clock
    input wire logic i_clk,
    // Device observation
    input wire logic i_dev_sdata,
    input wire logic i_dev_oe,
    input wire logic i_hold,
    input wire logic i_power,
    // Link
    output logic o_sclk,
    output logic o_mux_sel_n,
    output logic o_conv_sel_n,
    output logic o_wire
);
    logic host_oe;
    logic host_d;
    logic last_r = 1'b0;

    // Undriven wire toggles every cycle so a stale level cannot pass
    assign o_wire = i_dev_oe ? i_dev_sdata : (host_oe ? host_d : ~last_r);

    always @(posedge i_clk) begin
        last_r <= o_wire;
    end

    initial begin
        o_sclk = 1'b0;
        o_mux_sel_n = 1'b1;
        o_conv_sel_n = 1'b1;
        host_oe = 1'b1;
        host_d = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Samples late in the high phase to clear the device's synchroniser lag
    task automatic frame(input logic [3:0] word, input bit sel_mux, input bit end_mux,
                         output logic [27:0] rx, output logic [27:0] hv, output logic [27:0] pv,
                         output logic [27:0] ov, output logic [2:0] idle);
        logic [5:0] bits;
        bits = {~word[1:0], word};
        if (sel_mux) begin
            for (int i = 5; i >= 0; i--) begin
                host_d <= bits[i];
                tick(4);
                o_sclk <= 1'b1;
                tick(4);
                o_sclk <= 1'b0;
            end
        end
        tick(4);
        @(negedge i_clk);
        idle = {i_power, i_hold, i_dev_oe};
        @(posedge i_clk);
        host_oe <= 1'b0;
        o_conv_sel_n <= 1'b0;
        if (sel_mux) o_mux_sel_n <= 1'b0;
        tick(8);
        for (int k = 0; k < 28; k++) begin
            o_sclk <= 1'b1;
            tick(3);
            @(negedge i_clk);
            rx[k] = o_wire;
            hv[k] = i_hold;
            pv[k] = i_power;
            ov[k] = i_dev_oe;
            @(posedge i_clk);
            o_sclk <= 1'b0;
            tick(4);
        end
        o_conv_sel_n <= 1'b1;
        if (end_mux) o_mux_sel_n <= 1'b1;
        tick(8);
        host_oe <= 1'b1;
        tick(8);
    endtask
endmodule

// ---- testbench/mux_adc_serial_control_tb.sv ----
// Self-checking bench for the serial converter control block
`timescale 1ns/1ps
module mux_adc_serial_control_tb
    import adc_serial_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, rd2;
    logic pready, pslverr, err, err2, sdata, sdata_oe, power, ref_on, hold;
    logic sclk, mux_n, conv_n, wire_d;
    logic [7:0] chan_on;
    logic [7:0] exp_chan = 8'h00;
    logic [3:0] wc = 4'h0;
    bit narrow = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 i_clk = ~i_clk;

    mux_adc_serial_control u_mux_adc_serial_control (
        .i_clk(i_clk), .i_srst(i_srst),
        .i_paddr(paddr), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sclk(sclk), .i_channel_address_select_n(mux_n), .i_conversion_select_n(conv_n),
        .i_sdata(wire_d), .o_sdata(sdata), .o_sdata_oe(sdata_oe),
        .o_chan_on(chan_on), .o_converter_power(power), .o_reference_connect(ref_on),
        .o_hold(hold)
    );

    host_link_model u_host_link_model (
        .i_clk(i_clk), .i_dev_sdata(sdata), .i_dev_oe(sdata_oe), .i_hold(hold),
        .i_power(power), .o_sclk(sclk), .o_mux_sel_n(mux_n), .o_conv_sel_n(conv_n),
        .o_wire(wire_d)
    );

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Ceiling well above the ~10k cycles the tests need
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            give_verdict();
        end
    end

    // Reference follows converter power; the two sides never drive the wire together
    always @(negedge i_clk) begin
        if (!i_srst) begin
            check(ref_on, power);
            check(u_host_link_model.host_oe & sdata_oe, 1'b0);
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdata, output logic perr);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        // Wait states come only from a full sample buffer; the bench timeout ends a hang
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(rd & mask, exp);
    endtask

    function automatic logic [11:0] code_of(input int i);
        if (i == 0) return 12'hFFF;
        if (i == 1) return 12'h000;
        return 12'(i * 12'h09D + 12'h2A5);
    endfunction

    function automatic logic [27:0] exp_data(input logic [11:0] c);
        logic [27:0] e;
        e = 28'h000_0000;
        for (int k = 3; k <= 14; k++) e[k] = c[14 - k];
        for (int k = 15; k <= 25; k++) e[k] = c[k - 14];
        return e;
    endfunction

    // One conversion frame; value index k is the state after k clock falls
    task automatic run(input bit sel, input bit endm, input logic [11:0] c);
        logic [27:0] rx, hv, pv, ov;
        logic [2:0] idle;
        logic [3:0] w;
        w = 4'(wc * 4'h5 + 4'h3);
        u_host_link_model.frame(w, sel, endm, rx, hv, pv, ov, idle);
        if (sel) begin
            wc = wc + 4'h1;
            exp_chan = w[3] ? 8'h01 << (narrow ? {1'b0, w[1:0]} : w[2:0]) : 8'h00;
        end
        check(idle, 3'h0);
        check(rx & 28'hFFF_FFFC, exp_data(c));
        check(hv, 28'h000_3FFC);
        check(pv, 28'h000_3FFF);
        check(ov, 28'hFFF_FFFC);
        check(chan_on, exp_chan);
        check(sdata_oe, 1'b0);
        rd_chk(OFS_RESULT, {20'h0_0000, c}, 32'h0000_0FFF);
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd_chk(OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
        rd_chk(OFS_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
        apb(1'b1, OFS_RESULT, 32'h0000_0ABC, rd, err);
        rd_chk(OFS_RESULT, 32'h0000_0000, 32'hFFFF_FFFF);
        apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
        $display("Test 1 registers done");
        for (int i = 0; i < 32; i++) apb(1'b1, OFS_SAMPLE, {20'h0_0000, code_of(i)}, rd, err);
        rd_chk(OFS_STATUS, 32'h0000_2000, 32'h0000_3F00);
        // Full buffer stalls this write until the frame's hold edge pops a word
        fork
            apb(1'b1, OFS_SAMPLE, {20'h0_0000, code_of(32)}, rd2, err2);
            run(1'b1, 1'b1, code_of(0));
        join
        check(err2, 1'b0);
        rd_chk(OFS_STATUS, 32'h0000_2000, 32'h0000_3F00);
        $display("Test 2 buffer full done");
        for (int i = 1; i <= 32; i++) begin
            if (i == 24) begin
                apb(1'b1, OFS_CTRL, 32'h0000_0001, rd, err);
                rd_chk(OFS_CTRL, 32'h0000_0001, 32'hFFFF_FFFF);
                narrow = 1'b1;
            end
            run(i % 4 != 3, i % 4 != 2, code_of(i));
        end
        $display("Test 3 conversions done");
        run(1'b1, 1'b1, 12'h000);
        rd_chk(OFS_STATUS, 32'h0000_0001, 32'h0000_3F01);
        apb(1'b1, OFS_STATUS, 32'h0000_0001, rd, err);
        rd_chk(OFS_STATUS, 32'h0000_0000, 32'h0000_3F01);
        $display("Test 4 underrun done");
        give_verdict();
    end
endmodule
